// ### logic/acrp_pkg.sv
// package of constants for the auxiliary converter calibration result path
// assumes a 32-bit axi4-lite slave, word registers at byte address = index * 4
package acrp_pkg;
	// register indices, byte address is four times the index
	localparam logic [5:0]  IDX_OFFSET    = 6'h00;     // offset trim value
	localparam logic [5:0]  IDX_GAIN      = 6'h01;     // gain trim value
	localparam logic [5:0]  IDX_CTRL      = 6'h02;     // control bits
	localparam logic [5:0]  IDX_STATUS    = 6'h03;     // read-only state
	localparam logic [5:0]  IDX_RES_FIRST = 6'h10;     // first step result
	localparam logic [5:0]  IDX_RES_LAST  = 6'h1f;     // last step result
	localparam int          ADDR_LSB      = 2;         // word alignment
	// reset values, trims are volatile
	localparam logic [15:0] OFFSET_RST    = 16'h0000;
	localparam logic [15:0] GAIN_RST      = 16'h0000;
	localparam logic        BIAS_EN_RST   = 1'b0;
	// field positions
	localparam int          CTRL_BIAS_BIT = 0;         // bias_buffer_enable
	localparam int          STAT_STEP_LSB = 0;         // last step written, 4 bits
	localparam int          STAT_CNT_LSB  = 8;         // results counter, 8 bits
	// aux_gain_setting codes
	localparam logic [1:0]  GAIN_X1       = 2'h0;
	localparam logic [1:0]  GAIN_X2       = 2'h1;
	localparam logic [1:0]  GAIN_X4       = 2'h2;
	// aux_input_selector code of the internal temperature sensor
	localparam logic [3:0]  SEL_TEMP_DEF  = 4'hf;
	// arithmetic constants
	localparam logic [17:0] UNITY         = 18'h10000; // factor 1.0 in 2^16 units
	localparam logic [35:0] RND_HALF      = 36'h000008000;
	localparam logic [15:0] POS_FS        = 16'h7fff;
	localparam logic [15:0] NEG_FS        = 16'h8000;
	localparam int          DP_LAT        = 2;         // raw in to result out, cycles
	// axi responses
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage

// ### logic/acrp_cal_if.sv
// carrier between the register side and the calibration datapath
// assumes both ends run on the same clock
interface acrp_cal_if;
	logic        in_valid;   // raw result strobe
	logic [3:0]  in_step;    // sequencer step of the raw result
	logic        in_bypass;  // temperature sensor, skip trims
	logic [1:0]  in_gain;    // aux_gain_setting of the step
	logic [15:0] in_raw;     // raw conversion code
	logic [15:0] offset;     // offset_trim_value
	logic [15:0] gain;       // gain_trim_value
	logic        out_valid;  // corrected result strobe
	logic [3:0]  out_step;   // step of the corrected result
	logic [15:0] out_data;   // corrected code
	modport ctl (output in_valid, in_step, in_bypass, in_gain, in_raw, offset, gain,
		input out_valid, out_step, out_data);
	modport dp (input in_valid, in_step, in_bypass, in_gain, in_raw, offset, gain,
		output out_valid, out_step, out_data);
endinterface

// ### logic/acrp_cal_dp.sv
// two-stage offset, gain, rounding and clipping datapath
// assumes trims are steady while a conversion is in flight
module acrp_cal_dp (
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	acrp_cal_if.dp    cal
);
	logic signed [17:0] off_scaled;   // offset in result lsbs
	logic signed [17:0] diff_next;    // raw minus offset
	logic signed [17:0] fac_next;     // 1 + gain/2^16
	logic signed [17:0] diff_reg;
	logic signed [17:0] fac_reg;
	logic               v1_reg;
	logic [3:0]         step1_reg;
	logic signed [35:0] prod;         // scaled, 2^16 fraction
	logic signed [35:0] rnd;          // after half-lsb add
	logic signed [19:0] q;            // integer part
	logic               v2_reg;
	logic [3:0]         step2_reg;
	logic [15:0]        data2_reg;

	// at gain 4 one trim lsb is two result lsbs, at gain 1 and 2 it is one
	assign off_scaled = (cal.in_gain == acrp_pkg::GAIN_X4) ?
		{{1{cal.offset[15]}}, cal.offset, 1'b0} : {{2{cal.offset[15]}}, cal.offset}; // R06
	// trim subtracted first, bypassed for the temperature sensor
	assign diff_next = cal.in_bypass ? {{2{cal.in_raw[15]}}, cal.in_raw} :
		18'({{2{cal.in_raw[15]}}, cal.in_raw} - off_scaled); // R01 R02 R05
	assign fac_next = cal.in_bypass ? acrp_pkg::UNITY :
		18'(acrp_pkg::UNITY + {{2{cal.gain[15]}}, cal.gain}); // R02 R07
	assign prod = diff_reg * fac_reg; // R01
	assign rnd  = prod + acrp_pkg::RND_HALF; // R03
	assign q    = rnd[35:16];

	// clip to 16-bit full scale codes
	function automatic logic [15:0] sat16(input logic signed [19:0] v);
		if (v > 20'sh07fff)
			sat16 = acrp_pkg::POS_FS;
		else if (v < -20'sh08000)
			sat16 = acrp_pkg::NEG_FS;
		else
			sat16 = v[15:0];
	endfunction

	// stage one: offset removal
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			v1_reg    <= 1'b0;
			step1_reg <= 4'h0;
			diff_reg  <= 18'sh0;
			fac_reg   <= 18'sh0;
		end else begin
			v1_reg <= cal.in_valid;
			if (cal.in_valid) begin
				step1_reg <= cal.in_step;
				diff_reg  <= diff_next;
				fac_reg   <= fac_next;
			end
		end
	end

	// stage two: scale, round, clip
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			v2_reg    <= 1'b0;
			step2_reg <= 4'h0;
			data2_reg <= 16'h0000;
		end else begin
			v2_reg <= v1_reg;
			if (v1_reg) begin
				step2_reg <= step1_reg;
				data2_reg <= sat16(q); // R03 R14
			end
		end
	end

	assign cal.out_valid = v2_reg;
	assign cal.out_step  = step2_reg;
	assign cal.out_data  = data2_reg;

	sequence s_bypass_in;
		cal.in_valid && cal.in_bypass;
	endsequence
	sequence s_plain_in;
		cal.in_valid && !cal.in_bypass && cal.offset == 16'h0000 && cal.gain == 16'h0000;
	endsequence

	a_bypass_keeps_raw: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R02
		s_bypass_in |-> ##2 cal.out_valid && cal.out_data == $past(cal.in_raw, 2))
		else $error("bypassed result differs from raw");
	a_zero_trim_unity: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R07
		s_plain_in ##0 (cal.in_gain != acrp_pkg::GAIN_X4) |-> ##2
		cal.out_data == $past(cal.in_raw, 2))
		else $error("zero trims changed the result");
	a_latency_two: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R15
		cal.in_valid |-> ##2 cal.out_valid && cal.out_step == $past(cal.in_step, 2))
		else $error("result not two cycles after raw");
	a_clip_bounds: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R14
		v1_reg && q > 20'sh07fff |=> cal.out_data == acrp_pkg::POS_FS)
		else $error("positive overrange not clipped");
endmodule

// ### logic/acrp_top.sv
// register side of the auxiliary converter result path: axi4-lite slave,
// trim and control registers, step result store, datapath instance
// assumes the sequencer drives its strobes on i_clk and only for settled results
// How it works
// R01 - subtract offset trim, then multiply by gain
// R02 - one trim pair; temperature sensor bypasses both
// R03 - round after scaling, then clip to full scale
// R04 - host reloads volatile trims after every reset
// R05 - offset trim is signed and subtracted
// R06 - offset lsb doubles weight relative at gain four
// R07 - gain factor is one plus trim over 2^16
// R08 - host zeroes both trims before calibrating
// R09 - host shorts input to ground, averages offset
// R10 - host derives gain trim from unclipped reference
// R11 - bias enable routes buffer to eighth channel
// R12 - host picks eighth channel as negative input
// R13 - step results readable at indices 10h to 1Fh
// R14 - results signed, clip at 7FFFh and 8000h
// R15 - only sequencer single-shot settled results enter
// R16 - temperature bypass judged per conversion from sequencer
module acrp_top #(
	parameter logic [3:0] TEMP_SEL = acrp_pkg::SEL_TEMP_DEF // temperature sensor code
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic [7:0]  i_s_axi_awaddr,
	input  wire logic [2:0]  i_s_axi_awprot,
	input  wire logic        i_s_axi_awvalid,
	output logic             o_s_axi_awready,
	input  wire logic [31:0] i_s_axi_wdata,
	input  wire logic [3:0]  i_s_axi_wstrb,
	input  wire logic        i_s_axi_wvalid,
	output logic             o_s_axi_wready,
	output logic [1:0]       o_s_axi_bresp,
	output logic             o_s_axi_bvalid,
	input  wire logic        i_s_axi_bready,
	input  wire logic [7:0]  i_s_axi_araddr,
	input  wire logic [2:0]  i_s_axi_arprot,
	input  wire logic        i_s_axi_arvalid,
	output logic             o_s_axi_arready,
	output logic [31:0]      o_s_axi_rdata,
	output logic [1:0]       o_s_axi_rresp,
	output logic             o_s_axi_rvalid,
	input  wire logic        i_s_axi_rready,
	input  wire logic        i_conv_start,
	input  wire logic        i_conv_valid,
	input  wire logic [3:0]  i_conv_step,
	input  wire logic [3:0]  i_conv_sel,
	input  wire logic [1:0]  i_conv_gain,
	input  wire logic [15:0] i_conv_raw,
	output logic             o_filter_restart,
	output logic             o_bias_buffer_enable,
	output logic             o_bias_to_eighth_aux_channel,
	output logic             o_result_valid,
	output logic [3:0]       o_result_step,
	output logic [15:0]      o_result_data
);
	acrp_cal_if cal ();

	// trims and control
	logic [15:0] offset_reg;     // offset_trim_value
	logic [15:0] gain_reg;       // gain_trim_value
	logic        bias_en_reg;    // bias_buffer_enable
	logic        restart_reg;    // filter restart pulse
	// result store and state
	logic [15:0] result_mem [16];
	logic [3:0]  last_step_reg;  // step of newest result
	logic [7:0]  conv_cnt_reg;   // results stored, wraps
	logic        res_v_reg;
	logic [3:0]  res_step_reg;
	logic [15:0] res_data_reg;
	// write channel state
	logic        aw_held_reg;
	logic [7:0]  aw_addr_reg;
	logic        w_held_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        awready_reg;
	logic        wready_reg;
	logic        bvalid_reg;
	logic [1:0]  bresp_reg;
	// read channel state
	logic        arready_reg;
	logic        rvalid_reg;
	logic [31:0] rdata_reg;
	logic [1:0]  rresp_reg;
	// probe value for the bypass check, a raw code that any nonzero offset trim changes
	localparam logic [15:0] NEG_ONE = 16'hffff;

	// word index of a byte address
	function automatic logic [5:0] word_idx(input logic [7:0] a);
		word_idx = a[7:acrp_pkg::ADDR_LSB];
	endfunction

	// index decodes to a mapped register
	function automatic logic idx_mapped(input logic [5:0] i);
		idx_mapped = (i <= acrp_pkg::IDX_STATUS) ||
			(i >= acrp_pkg::IDX_RES_FIRST && i <= acrp_pkg::IDX_RES_LAST);
	endfunction

	// write handshake decode
	// either half may come first; the held copy stands in for the missing one
	wire         aw_take   = i_s_axi_awvalid & awready_reg;
	wire         w_take    = i_s_axi_wvalid & wready_reg;
	wire         aw_have   = aw_held_reg | aw_take;
	wire         w_have    = w_held_reg | w_take;
	wire         do_write  = aw_have & w_have;
	wire [7:0]   wr_addr   = aw_take ? i_s_axi_awaddr : aw_addr_reg;
	wire [31:0]  wr_data   = w_take ? i_s_axi_wdata : w_data_reg;
	wire [3:0]   wr_strb   = w_take ? i_s_axi_wstrb : w_strb_reg;
	wire [5:0]   wr_idx    = word_idx(wr_addr);
	wire         wr_ok     = idx_mapped(wr_idx);
	wire         aw_h_next = aw_have & ~do_write;
	wire         w_h_next  = w_have & ~do_write;
	wire         bv_next   = do_write | (bvalid_reg & ~i_s_axi_bready);
	wire         wr_off    = do_write && wr_idx == acrp_pkg::IDX_OFFSET;
	wire         wr_gain   = do_write && wr_idx == acrp_pkg::IDX_GAIN;
	wire         wr_ctrl   = do_write && wr_idx == acrp_pkg::IDX_CTRL;

	// read handshake decode
	wire         ar_take   = i_s_axi_arvalid & arready_reg;
	wire         rv_next   = ar_take | (rvalid_reg & ~i_s_axi_rready);
	wire [5:0]   rd_idx    = word_idx(i_s_axi_araddr);
	wire         rd_ok     = idx_mapped(rd_idx);
	wire         rd_res    = rd_idx >= acrp_pkg::IDX_RES_FIRST;
	wire [31:0]  stat_word = {16'h0000, conv_cnt_reg, 4'h0, last_step_reg};
	wire [31:0]  rd_word   =
		!rd_ok                             ? 32'h0000_0000 :
		rd_res                             ? {16'h0000, result_mem[rd_idx[3:0]]} : // R13
		rd_idx == acrp_pkg::IDX_OFFSET     ? {16'h0000, offset_reg} :
		rd_idx == acrp_pkg::IDX_GAIN       ? {16'h0000, gain_reg} :
		rd_idx == acrp_pkg::IDX_CTRL       ? {31'h0, bias_en_reg} :
		stat_word;

	// sequencer to datapath, bypass judged from this conversion's selector
	assign cal.in_valid  = i_conv_valid; // R15
	assign cal.in_step   = i_conv_step;
	assign cal.in_bypass = (i_conv_sel == TEMP_SEL); // R16 R02
	assign cal.in_gain   = i_conv_gain;
	assign cal.in_raw    = i_conv_raw;
	assign cal.offset    = offset_reg; // R02
	assign cal.gain      = gain_reg;

	acrp_cal_dp u_dp (
		.i_clk   (i_clk),
		.i_rst_n (i_rst_n),
		.cal     (cal)
	);

	// write address and data captured in either order
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg  <= 32'h0000_0000;
			w_strb_reg  <= 4'h0;
		end else begin
			aw_held_reg <= aw_h_next;
			w_held_reg  <= w_h_next;
			if (aw_take)
				aw_addr_reg <= i_s_axi_awaddr;
			if (w_take) begin
				w_data_reg <= i_s_axi_wdata;
				w_strb_reg <= i_s_axi_wstrb;
			end
		end
	end

	// each ready stays low while its own half is held or a response waits
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= acrp_pkg::RESP_OKAY;
		end else begin
			awready_reg <= ~aw_h_next & ~bv_next;
			wready_reg  <= ~w_h_next & ~bv_next;
			bvalid_reg  <= bv_next;
			if (do_write)
				bresp_reg <= wr_ok ? acrp_pkg::RESP_OKAY : acrp_pkg::RESP_SLVERR;
		end
	end

	// trims are volatile, cleared on every reset; host reloads them
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			offset_reg  <= acrp_pkg::OFFSET_RST; // R04
			gain_reg    <= acrp_pkg::GAIN_RST;
			bias_en_reg <= acrp_pkg::BIAS_EN_RST;
		end else begin
			if (wr_off && wr_strb[0])
				offset_reg[7:0] <= wr_data[7:0];
			if (wr_off && wr_strb[1])
				offset_reg[15:8] <= wr_data[15:8];
			if (wr_gain && wr_strb[0])
				gain_reg[7:0] <= wr_data[7:0];
			if (wr_gain && wr_strb[1])
				gain_reg[15:8] <= wr_data[15:8];
			if (wr_ctrl && wr_strb[0])
				bias_en_reg <= wr_data[acrp_pkg::CTRL_BIAS_BIT]; // R11
		end
	end

	// reads answer one cycle after the address is taken
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0000_0000;
			rresp_reg   <= acrp_pkg::RESP_OKAY;
		end else begin
			arready_reg <= ~rv_next;
			rvalid_reg  <= rv_next;
			if (ar_take) begin
				rdata_reg <= rd_word;
				rresp_reg <= rd_ok ? acrp_pkg::RESP_OKAY : acrp_pkg::RESP_SLVERR;
			end
		end
	end

	// step results land in their slot; results are read-only to the bus
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			for (int k = 0; k < 16; k++)
				result_mem[k] <= 16'h0000;
			last_step_reg <= 4'h0;
			conv_cnt_reg  <= 8'h00;
		end else if (cal.out_valid) begin
			result_mem[cal.out_step] <= cal.out_data; // R13
			last_step_reg <= cal.out_step;
			conv_cnt_reg  <= conv_cnt_reg + 8'h01;
		end
	end

	// result echo and filter restart, all registered outputs
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			res_v_reg    <= 1'b0;
			res_step_reg <= 4'h0;
			res_data_reg <= 16'h0000;
			restart_reg  <= 1'b0;
		end else begin
			res_v_reg   <= cal.out_valid;
			restart_reg <= i_conv_start; // R15
			if (cal.out_valid) begin
				res_step_reg <= cal.out_step;
				res_data_reg <= cal.out_data;
			end
		end
	end

	assign o_s_axi_awready              = awready_reg;
	assign o_s_axi_wready               = wready_reg;
	assign o_s_axi_bvalid               = bvalid_reg;
	assign o_s_axi_bresp                = bresp_reg;
	assign o_s_axi_arready              = arready_reg;
	assign o_s_axi_rvalid               = rvalid_reg;
	assign o_s_axi_rdata                = rdata_reg;
	assign o_s_axi_rresp                = rresp_reg;
	assign o_filter_restart             = restart_reg;
	assign o_bias_buffer_enable         = bias_en_reg;
	assign o_bias_to_eighth_aux_channel = bias_en_reg; // R11
	assign o_result_valid               = res_v_reg;
	assign o_result_step                = res_step_reg;
	assign o_result_data                = res_data_reg;

	// register side checks; a response may stand several cycles for a slow
	// host, so only the cycle right after the take is looked at here
	sequence s_offset_write;
		wr_off && wr_strb[1:0] == 2'h3;
	endsequence

	a_offset_trim_load: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R05
		s_offset_write |=> offset_reg == $past(wr_data[15:0]))
		else $error("offset trim not loaded");
	a_bias_follow_ctrl: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R11
		wr_ctrl && wr_strb[0] |=> o_bias_to_eighth_aux_channel == $past(wr_data[0]))
		else $error("bias routing does not follow control");
	a_result_slot_store: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R13
		cal.out_valid |=> result_mem[$past(cal.out_step)] == $past(cal.out_data))
		else $error("result not stored in its step slot");
	a_read_result_data: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R13
		ar_take && rd_ok && rd_res && !cal.out_valid |=>
		o_s_axi_rvalid && o_s_axi_rdata[15:0] == $past(result_mem[rd_idx[3:0]]))
		else $error("result read returns wrong data");
	a_write_response: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		do_write |=> o_s_axi_bvalid && !o_s_axi_awready && !o_s_axi_wready)
		else $error("write response missing");
	a_read_answer: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		ar_take |=> o_s_axi_rvalid && !o_s_axi_arready)
		else $error("read answer missing");
	a_unmapped_slverr: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		ar_take && !rd_ok |=> o_s_axi_rresp == acrp_pkg::RESP_SLVERR && o_s_axi_rdata == 0)
		else $error("unmapped read not refused");
	a_temp_bypass_sel: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R16
		i_conv_valid && i_conv_sel == TEMP_SEL && i_conv_raw == NEG_ONE |-> ##3
		o_result_valid && o_result_data == NEG_ONE)
		else $error("temperature result was trimmed");
	a_restart_pulse: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R15
		i_conv_start |=> o_filter_restart)
		else $error("filter restart not issued");
	a_count_step: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		cal.out_valid |=> conv_cnt_reg == 8'($past(conv_cnt_reg) + 8'h01))
		else $error("result count not advanced");
endmodule

// ### verification/acrp_axi_host.sv
// axi4-lite host model: one register write or read per task call
// assumes callers enter a task just after a rising edge of i_clk
module acrp_axi_host (
	input  wire logic        i_clk,
	output logic [7:0]       o_awaddr,
	output logic             o_awvalid,
	input  wire logic        i_awready,
	output logic [31:0]      o_wdata,
	output logic [3:0]       o_wstrb,
	output logic             o_wvalid,
	input  wire logic        i_wready,
	input  wire logic [1:0]  i_bresp,
	input  wire logic        i_bvalid,
	output logic             o_bready,
	output logic [7:0]       o_araddr,
	output logic             o_arvalid,
	input  wire logic        i_arready,
	input  wire logic [31:0] i_rdata,
	input  wire logic [1:0]  i_rresp,
	input  wire logic        i_rvalid,
	output logic             o_rready
);
	timeunit 1ns;
	timeprecision 1ps;
	// idle bus at time zero; bready and rready stay high throughout
	initial begin
		{o_awvalid, o_wvalid, o_arvalid} = 3'h0;
		{o_bready, o_rready} = 2'h3;
		{o_awaddr, o_araddr, o_wdata, o_wstrb} = '0;
	end
	// write; released address and data show their inverse so stale values never pass, o_wstrb keeps its value
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		logic done;
		done = 1'h0;
		o_awaddr  <= a;
		o_awvalid <= 1'h1;
		o_wdata   <= d;
		o_wstrb   <= s;
		o_wvalid  <= 1'h1;
		while (!done) begin
			@(posedge i_clk);
			if (o_awvalid && i_awready) begin
				o_awvalid <= 1'h0;
				o_awaddr  <= ~a;
			end
			if (o_wvalid && i_wready) begin
				o_wvalid <= 1'h0;
				o_wdata  <= ~d;
			end
			if (o_bready && i_bvalid) begin
				r = i_bresp;
				done = 1'h1;
			end
		end
	endtask
	// read; rready held until rvalid is sampled
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic done;
		done = 1'h0;
		o_araddr  <= a;
		o_arvalid <= 1'h1;
		while (!done) begin
			@(posedge i_clk);
			if (o_arvalid && i_arready) begin
				o_arvalid <= 1'h0;
				o_araddr  <= ~a;
			end
			if (o_rready && i_rvalid) begin
				d = i_rdata;
				r = i_rresp;
				done = 1'h1;
			end
		end
	endtask
endmodule

// ### verification/tb.sv
// self-checking bench of the converter result path top
// assumes the host model answers bus calls and the bench plays the sequencer
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [15:0] raw, off, gtrim;
		logic [1:0]  gc;
		logic [3:0]  sel, step;
		logic [15:0] res;
	} acrp_row_t;                    // inputs beside the expected code
	logic        i_clk, i_rst_n;
	logic [7:0]  i_s_axi_awaddr, i_s_axi_araddr;
	logic [31:0] i_s_axi_wdata, o_s_axi_rdata, d;
	logic [3:0]  i_s_axi_wstrb, i_conv_step, i_conv_sel, o_result_step, st;
	logic [1:0]  o_s_axi_bresp, o_s_axi_rresp, i_conv_gain, r;
	logic [15:0] i_conv_raw, o_result_data, d16;
	logic        i_s_axi_awvalid, o_s_axi_awready, i_s_axi_wvalid, o_s_axi_wready;
	logic        o_s_axi_bvalid, i_s_axi_bready, i_s_axi_arvalid, o_s_axi_arready;
	logic        o_s_axi_rvalid, i_s_axi_rready, i_conv_start, i_conv_valid;
	logic        o_filter_restart, o_bias_buffer_enable, o_bias_to_eighth_aux_channel;
	logic        o_result_valid;
	int          fail_count = 0, checked = 0, restarts = 0, cyc = 0;
	acrp_row_t   rows [14];
	// prot lines tied, the design ignores them
	acrp_top dut_u (.i_clk, .i_rst_n, .i_s_axi_awaddr, .i_s_axi_awprot(3'h0), .i_s_axi_awvalid,
		.o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready,
		.o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr,
		.i_s_axi_arprot(3'h0), .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata,
		.o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready, .i_conv_start, .i_conv_valid,
		.i_conv_step, .i_conv_sel, .i_conv_gain, .i_conv_raw, .o_filter_restart,
		.o_bias_buffer_enable, .o_bias_to_eighth_aux_channel, .o_result_valid,
		.o_result_step, .o_result_data);
	acrp_axi_host host_u (.i_clk(i_clk), .o_awaddr(i_s_axi_awaddr), .o_awvalid(i_s_axi_awvalid),
		.i_awready(o_s_axi_awready), .o_wdata(i_s_axi_wdata), .o_wstrb(i_s_axi_wstrb),
		.o_wvalid(i_s_axi_wvalid), .i_wready(o_s_axi_wready), .i_bresp(o_s_axi_bresp),
		.i_bvalid(o_s_axi_bvalid), .o_bready(i_s_axi_bready), .o_araddr(i_s_axi_araddr),
		.o_arvalid(i_s_axi_arvalid), .i_arready(o_s_axi_arready), .i_rdata(o_s_axi_rdata),
		.i_rresp(o_s_axi_rresp), .i_rvalid(o_s_axi_rvalid), .o_rready(i_s_axi_rready));
	// 100 MHz clock
	initial begin
		i_clk = 1'h0;
		forever #5 i_clk = ~i_clk;
	end
	// restart pulse count and hang guard, ceiling well above the ~200 cycles used
	always @(posedge i_clk) begin
		if (o_filter_restart === 1'h1) restarts++;
		cyc++;
		if (cyc == 8000) begin
			fail_count++;
			end_of_test();
		end
	end
	task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		chk_data({30'h0, got}, {30'h0, exp});
	endtask
	task automatic end_of_test();
		$display("checked=%0d fail_count=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// reset held 5 cycles
	task automatic do_reset();
		i_rst_n <= 1'h0;
		repeat (5) @(posedge i_clk);
		i_rst_n <= 1'h1;
		@(posedge i_clk);
	endtask
	// one settled raw result; caller lowers valid after the last one
	task automatic conv(input logic [15:0] raw, input logic [1:0] gc, input logic [3:0] sel,
		input logic [3:0] stp);
		i_conv_valid <= 1'h1;
		i_conv_raw   <= raw;
		i_conv_gain  <= gc;
		i_conv_sel   <= sel;
		i_conv_step  <= stp;
		@(posedge i_clk);
	endtask
	// next corrected result, bounded wait
	task automatic get_res(output logic [15:0] dd, output logic [3:0] ss);
		int n;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (o_result_valid !== 1'h1 && n < 12);
		dd = o_result_data;
		ss = o_result_step;
	endtask
	initial begin
		i_rst_n = 1'h0;
		{i_conv_start, i_conv_valid, i_conv_step, i_conv_sel, i_conv_gain, i_conv_raw} = '0;
		rows = '{{16'h0100, 16'h0010, 16'h0000, 2'h0, 4'h0, 4'h0, 16'h00f0},
			{16'h0100, 16'hfff0, 16'h0000, 2'h0, 4'h1, 4'h1, 16'h0110},
			{16'h0100, 16'h0010, 16'h0000, 2'h2, 4'h2, 4'h2, 16'h00e0},
			{16'h0100, 16'h0010, 16'h0000, 2'h1, 4'h3, 4'h3, 16'h00f0},
			{16'h2000, 16'h0000, 16'h7fff, 2'h0, 4'h4, 4'h4, 16'h3000},
			{16'h2000, 16'h0000, 16'h8000, 2'h0, 4'h5, 4'h5, 16'h1000},
			{16'h7000, 16'h0000, 16'h7fff, 2'h0, 4'h6, 4'h6, 16'h7fff},
			{16'h8000, 16'h0010, 16'h0000, 2'h0, 4'h7, 4'h7, 16'h8000},
			{16'h0100, 16'h0010, 16'h8000, 2'h0, 4'hf, 4'h8, 16'h0100},
			{16'h0001, 16'h0000, 16'h8000, 2'h0, 4'h0, 4'h9, 16'h0001},
			{16'hffff, 16'h0000, 16'h8000, 2'h0, 4'h0, 4'ha, 16'h0000},
			{16'h0100, 16'h0010, 16'h8000, 2'h0, 4'h0, 4'hb, 16'h0078},
			{16'h6fb6, 16'h0000, 16'h199a, 2'h0, 4'h0, 4'hc, 16'h7ae2},
			{16'h0005, 16'h0000, 16'h0000, 2'h0, 4'h9, 4'hf, 16'h0005}};
		do_reset();
		// trims, control, status and first result all clear after reset
		for (int a = 0; a < 5; a++) begin
			host_u.rd(8'(a < 4 ? a * 4 : 64), d, r);
			chk_data(d, 32'h0);
		end
		host_u.wr(8'h08, 32'h1, 4'hf, r);
		chk_data({30'h0, o_bias_buffer_enable, o_bias_to_eighth_aux_channel}, 32'h3);
		host_u.wr(8'h08, 32'h0, 4'hf, r);
		@(posedge i_clk);
		chk_data({30'h0, o_bias_buffer_enable, o_bias_to_eighth_aux_channel}, 32'h0);
		// byte lanes written one at a time
		host_u.wr(8'h00, 32'h1234_5678, 4'h1, r);
		host_u.wr(8'h00, 32'hffff_ab00, 4'h2, r);
		host_u.rd(8'h00, d, r);
		chk_data(d, 32'h0000_ab78);
		// unmapped index refused both ways
		host_u.wr(8'h10, 32'h1, 4'hf, r);
		chk_resp(r, acrp_pkg::RESP_SLVERR);
		host_u.rd(8'h10, d, r);
		chk_resp(r, acrp_pkg::RESP_SLVERR);
		chk_data(d, 32'h0);
		// ordinary cases: trims, one conversion, pulse and stored result
		for (int k = 0; k < 14; k++) begin
			host_u.wr(8'h00, {16'h0, rows[k].off}, 4'hf, r);
			host_u.wr(8'h04, {16'h0, rows[k].gtrim}, 4'hf, r);
			conv(rows[k].raw, rows[k].gc, rows[k].sel, rows[k].step);
			i_conv_valid <= 1'h0;
			get_res(d16, st);
			chk_data({16'h0, d16}, {16'h0, rows[k].res});
			chk_data({28'h0, st}, {28'h0, rows[k].step});
			host_u.rd({2'h1, rows[k].step, 2'h0}, d, r);
			chk_data(d, {16'h0, rows[k].res});
		end
		// back to back, bypass judged per conversion
		host_u.wr(8'h00, 32'h10, 4'hf, r);
		host_u.wr(8'h04, 32'h0, 4'hf, r);
		conv(16'h0100, 2'h0, 4'hf, 4'h1);
		conv(16'h0100, 2'h0, 4'h0, 4'h2);
		conv(16'hffff, 2'h0, 4'hf, 4'h3);
		i_conv_valid <= 1'h0;
		for (int k = 0; k < 3; k++) begin
			get_res(d16, st);
			chk_data({16'h0, d16}, k == 0 ? 32'h100 : k == 1 ? 32'hf0 : 32'hffff);
		end
		// read-only places ignore writes
		host_u.wr(8'h0c, 32'hffff_ffff, 4'hf, r);
		chk_resp(r, acrp_pkg::RESP_OKAY);
		host_u.rd(8'h0c, d, r);
		chk_data(d, 32'h0000_1103);
		host_u.wr(8'h44, 32'hffff, 4'hf, r);
		host_u.rd(8'h44, d, r);
		chk_data(d, 32'h100);
		// one start gives one filter restart
		i_conv_start <= 1'h1;
		@(posedge i_clk);
		i_conv_start <= 1'h0;
		repeat (3) @(posedge i_clk);
		chk_data(32'(restarts), 32'h1);
		// second reset loses trims and results, host reloads
		do_reset();
		host_u.rd(8'h00, d, r);
		chk_data(d, 32'h0);
		host_u.rd(8'h44, d, r);
		chk_data(d, 32'h0);
		host_u.wr(8'h00, 32'h10, 4'hf, r);
		host_u.rd(8'h00, d, r);
		chk_data(d, 32'h10);
		end_of_test();
	end
endmodule
